// file: hw/srbs_regs.svh
// Constants of the serial ROM boot sequencer: offsets, fields, resets, counts.
// Assumes a 100 MHz core clock and one aligned 32-bit word per register.
`ifndef SRBS_REGS_SVH
`define SRBS_REGS_SVH

// ----------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------
`define SRBS_CTRL_OFS        8'h00
`define SRBS_STATUS_OFS      8'h04
`define SRBS_EXPECT_OFS      8'h08

// ----------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------
`define SRBS_CTRL_ANA_BIT    0
`define SRBS_CTRL_RESET      1'h1
`define SRBS_STAT_DONE_BIT   4
`define SRBS_STAT_ERR_BIT    5
`define SRBS_STAT_MEMEN_BIT  6
`define SRBS_EXPECT_RESET    8'hA5

// ----------------------------------------------------------------
// Timing and sizes: divider in core clock cycles, load and tail in configuration clock cycles
// ----------------------------------------------------------------
`define SRBS_RING_DIV        8
`define SRBS_DIV_LAST        3'h7
`define SRBS_CFG_CYCLES      14'h371D
`define SRBS_TAIL_CYCLES     2'h2
`define SRBS_HDR_BITS        4'h8
`define SRBS_SRAM_ROWS       7'h40
`define SRBS_POR_BITS        17

`endif

// file: hw/srbs_pkg.sv
// Types shared by the serial ROM boot sequencer.
// Assumes no other package defines the srbs_ prefix.
package srbs_pkg;

    typedef enum logic [3:0] {
        SRBS_ST_POR    = 4'b0000,
        SRBS_ST_CLEAR  = 4'b0001,
        SRBS_ST_HOLD   = 4'b0010,
        SRBS_ST_MICRO  = 4'b0011,
        SRBS_ST_LOAD   = 4'b0100,
        SRBS_ST_TAIL   = 4'b0101,
        SRBS_ST_DONE   = 4'b0110,
        SRBS_ST_ERROR  = 4'b0111,
        SRBS_ST_RBWAIT = 4'b1000
    } srbs_state_t;

    typedef logic [31:0] srbs_word_t;

endpackage

// file: hw/srbs_edge.sv
// Edge detector for one pin sampled on the core clock.
// Assumes the pin is already synchronous to core_clk.
`timescale 1ns/100ps
module srbs_edge #(
    parameter logic RST_LVL = 1'b1
) (
    // Clock and reset
    input  wire logic core_clk,
    input  wire logic rst,
    // Pin and edges
    input  wire logic din,
    output wire logic rise,
    output wire logic fall
);
    logic prev_r;

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            prev_r <= RST_LVL;
        end else begin
            prev_r <= din;
        end
    end

    assign rise = din & ~prev_r;
    assign fall = ~din & prev_r;
endmodule

// file: hw/srbs_top.sv
// Serial ROM boot sequencer: reset stretching, SRAM clearing, serial load.
// Assumes pins synchronous to core_clk and a single AHB-Lite master.
//
// Behaviour
// R1 - Boot select high: self-driven serial boot
// R2 - Source low: ring divided by eight, output
// R3 - Source high: clock pin is input clock
// R4 - After power-on reset, wait chip reset release
// R5 - Start: clocks run, memory enable low
// R6 - Capture data bit each serial clock rise
// R7 - Serial clock period is two configuration cycles
// R8 - Reboot falling edge restarts load, no reset
// R9 - Chip reset low idles; rise reconfigures
// R10 - Bitstream error: pull error low, halt
// R11 - Reboot asserted clears done, error quickly
// R12 - Reboot released: enable low within three
// R13 - Memory enable releases two cycles after done
// R14 - Load takes exactly 14109 configuration cycles
// R15 - Power-on pulse starts 17-bit stretch counter
// R16 - Reset: analog down, clear SRAM until rollover
// R17 - Rollover: clear once, then hold or configure
// R18 - Manual power-on rise gives full sequence
// R19 - Chip reset fall clears SRAM once
//
// The implementer's own choices: the address map and the AHB-Lite interface to the registers.
`timescale 1ns/100ps
`include "srbs_regs.svh"
module srbs_top #(
    parameter int POR_BITS = `SRBS_POR_BITS
) (
    // Clock and reset
    input  wire logic               core_clk,
    input  wire logic               rst,
    // AHB-Lite slave
    input  wire logic               hsel,
    input  wire logic [31:0]        haddr,
    input  wire logic [1:0]         htrans,
    input  wire logic               hwrite,
    input  wire logic [2:0]         hsize,
    input  wire srbs_pkg::srbs_word_t hwdata,
    input  wire logic               hready,
    output srbs_pkg::srbs_word_t    hrdata,
    output logic                    hreadyout,
    output logic                    hresp,
    // Mode and reset pins
    input  wire logic               boot_select,
    input  wire logic               clk_source_select,
    input  wire logic               chip_reset_n,
    input  wire logic               reboot_request_n,
    input  wire logic               power_on_pin,
    input  wire logic               analog_power_on_pulse,
    // Configuration clock pin
    input  wire logic               cfg_clk_in,
    output logic                    cfg_clk_out,
    output logic                    cfg_clk_oe_n,
    // Serial memory
    output logic                    serial_memory_clock,
    output logic                    memory_enable_n,
    input  wire logic               serial_data_in,
    // Status pins
    output logic                    config_done,
    output logic                    config_error_out,
    output logic                    config_error_oe_n,
    // Core side
    output logic                    analog_enable,
    output logic [6:0]              sram_row,
    output logic                    sram_clear,
    output logic                    cfg_bit,
    output logic                    cfg_bit_valid
);
    import srbs_pkg::*;
    default clocking cb_core @(posedge core_clk); endclocking
    default disable iff (rst);

    // ----------------------------------------------------------------
    // Pin edges
    // ----------------------------------------------------------------
    logic rb_rise, rb_fall, cr_rise, cr_fall, pp_rise, cc_rise, ap_rise;
    logic unused_fall0, unused_fall1, unused_fall2;
    srbs_edge #(.RST_LVL(1'b1)) u_rb (.core_clk(core_clk), .rst(rst), .din(reboot_request_n),
        .rise(rb_rise), .fall(rb_fall));
    srbs_edge #(.RST_LVL(1'b1)) u_cr (.core_clk(core_clk), .rst(rst), .din(chip_reset_n),
        .rise(cr_rise), .fall(cr_fall));
    srbs_edge #(.RST_LVL(1'b0)) u_pp (.core_clk(core_clk), .rst(rst), .din(power_on_pin),
        .rise(pp_rise), .fall(unused_fall0));
    srbs_edge #(.RST_LVL(1'b0)) u_cc (.core_clk(core_clk), .rst(rst), .din(cfg_clk_in),
        .rise(cc_rise), .fall(unused_fall1));
    srbs_edge #(.RST_LVL(1'b0)) u_ap (.core_clk(core_clk), .rst(rst), .din(analog_power_on_pulse),
        .rise(ap_rise), .fall(unused_fall2));

    // ----------------------------------------------------------------
    // Configuration clock
    // ----------------------------------------------------------------
    // Ring oscillator stands in as the core clock; divider gives the tick
    logic [2:0] div_r;
    logic       cfg_tick;
    assign cfg_tick = clk_source_select ? cc_rise : (div_r == `SRBS_DIV_LAST); // R2 R3
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            div_r        <= 3'h0;
            cfg_clk_out  <= 1'b0;
            cfg_clk_oe_n <= 1'b1;
        end else begin
            div_r        <= div_r + 3'h1;
            cfg_clk_out  <= div_r[2];              // R2
            cfg_clk_oe_n <= clk_source_select;     // R2 R3
        end
    end

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    logic       ctrl_ana_r;
    logic [7:0] expect_r;
    logic       wr_pend_r;
    logic [7:0] wr_addr_r;
    logic       addr_ok;
    srbs_word_t status_word, rd_word;
    srbs_state_t state_r;
    assign addr_ok = hsel & htrans[1] & hready;
    assign status_word = {25'h0, ~memory_enable_n, config_error_oe_n ? 1'b0 : 1'b1,
                          config_done, state_r};
    assign rd_word = (haddr[7:0] == `SRBS_CTRL_OFS)   ? {31'h0, ctrl_ana_r} :
                     (haddr[7:0] == `SRBS_STATUS_OFS) ? status_word :
                     (haddr[7:0] == `SRBS_EXPECT_OFS) ? {24'h0, expect_r} : 32'h0;
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            hrdata     <= 32'h0;
            hreadyout  <= 1'b1;
            hresp      <= 1'b0;
            wr_pend_r  <= 1'b0;
            wr_addr_r  <= 8'h00;
            ctrl_ana_r <= `SRBS_CTRL_RESET;
            expect_r   <= `SRBS_EXPECT_RESET;
        end else begin
            wr_pend_r <= addr_ok & hwrite;
            wr_addr_r <= haddr[7:0];
            if (addr_ok && !hwrite) begin
                hrdata <= rd_word;
            end
            if (wr_pend_r && wr_addr_r == `SRBS_CTRL_OFS) begin
                ctrl_ana_r <= hwdata[`SRBS_CTRL_ANA_BIT];
            end
            if (wr_pend_r && wr_addr_r == `SRBS_EXPECT_OFS) begin
                expect_r <= hwdata[7:0];
            end
        end
    end

    // ----------------------------------------------------------------
    // Sequencer
    // ----------------------------------------------------------------
    logic [POR_BITS-1:0] por_cnt_r;
    logic [13:0]         cyc_r;
    logic [1:0]          tail_r;
    logic [3:0]          bits_r;
    logic [7:0]          hdr_r;
    logic                por_roll, rows_end, in_reset, load_ready, hdr_bad, serial_memory_clock_up;
    assign por_roll   = cfg_tick && (&por_cnt_r);
    assign rows_end   = (sram_row == `SRBS_SRAM_ROWS - 7'h1);
    assign in_reset   = (state_r == SRBS_ST_POR) || (state_r == SRBS_ST_CLEAR) || (state_r == SRBS_ST_HOLD);
    assign load_ready = boot_select && !in_reset && (state_r != SRBS_ST_MICRO);
    assign serial_memory_clock_up    = cfg_tick && !serial_memory_clock;
    assign hdr_bad    = ({hdr_r[6:0], serial_data_in} != expect_r);
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            state_r             <= SRBS_ST_POR;
            por_cnt_r           <= '0;
            cyc_r               <= 14'h0;
            tail_r              <= 2'h0;
            bits_r              <= 4'h0;
            hdr_r               <= 8'h00;
            sram_row            <= 7'h00;
            sram_clear          <= 1'b0;
            serial_memory_clock <= 1'b0;
            memory_enable_n     <= 1'b1;
            config_done         <= 1'b0;
            config_error_out    <= 1'b0;
            config_error_oe_n   <= 1'b1;
            analog_enable       <= 1'b0;
            cfg_bit             <= 1'b0;
            cfg_bit_valid       <= 1'b0;
        end else begin
            cfg_bit_valid <= 1'b0;
            sram_clear    <= 1'b0;
            analog_enable <= (state_r == SRBS_ST_DONE) && ctrl_ana_r;   // R16
            if (ap_rise || (pp_rise && chip_reset_n)) begin             // R15 R18
                state_r             <= SRBS_ST_POR;
                por_cnt_r           <= '0;
                sram_row            <= 7'h00;
                memory_enable_n     <= 1'b1;
                serial_memory_clock <= 1'b0;
                config_done         <= 1'b0;
                config_error_oe_n   <= 1'b1;
                analog_enable       <= 1'b0;
            end else if (cr_fall && !power_on_pin && state_r != SRBS_ST_POR) begin // R19
                state_r             <= SRBS_ST_CLEAR;
                sram_row            <= 7'h00;
                memory_enable_n     <= 1'b1;
                serial_memory_clock <= 1'b0;
                config_done         <= 1'b0;
                config_error_oe_n   <= 1'b1;
                analog_enable       <= 1'b0;
            end else if (rb_fall && load_ready) begin                   // R8
                state_r             <= SRBS_ST_RBWAIT;
                config_done         <= 1'b0;                            // R11
                config_error_oe_n   <= 1'b1;                            // R11
                memory_enable_n     <= 1'b1;
                serial_memory_clock <= 1'b0;
            end else begin
                unique case (state_r)
                    SRBS_ST_POR: begin
                        // Sweep rows for the whole stretch; the sweep is cheap
                        if (cfg_tick) begin                             // R16
                            por_cnt_r  <= por_cnt_r + 1'b1;             // R15
                            sram_row   <= rows_end ? 7'h00 : sram_row + 7'h1;
                            sram_clear <= 1'b1;
                        end
                        if (por_roll) begin                             // R17
                            state_r  <= SRBS_ST_CLEAR;
                            sram_row <= 7'h00;
                        end
                    end
                    SRBS_ST_CLEAR: begin
                        if (cfg_tick) begin                             // R17 R19
                            sram_clear <= 1'b1;
                            sram_row   <= sram_row + 7'h1;
                            if (rows_end) begin
                                sram_row <= 7'h00;
                                state_r  <= !chip_reset_n ? SRBS_ST_HOLD :            // R4
                                            boot_select   ? SRBS_ST_LOAD : SRBS_ST_MICRO; // R1
                                if (chip_reset_n && boot_select) begin
                                    memory_enable_n <= 1'b0;            // R5
                                    cyc_r           <= 14'h0;
                                    bits_r          <= 4'h0;
                                end
                            end
                        end
                    end
                    SRBS_ST_HOLD: begin
                        if (cr_rise) begin                              // R9
                            state_r         <= boot_select ? SRBS_ST_LOAD : SRBS_ST_MICRO;
                            memory_enable_n <= ~boot_select;
                            cyc_r           <= 14'h0;
                            bits_r          <= 4'h0;
                        end
                    end
                    SRBS_ST_RBWAIT: begin
                        if (reboot_request_n) begin                     // R12
                            state_r         <= SRBS_ST_LOAD;
                            memory_enable_n <= 1'b0;
                            cyc_r           <= 14'h0;
                            bits_r          <= 4'h0;
                        end
                    end
                    SRBS_ST_LOAD: begin
                        if (cfg_tick) begin
                            cyc_r               <= cyc_r + 14'h1;
                            serial_memory_clock <= ~serial_memory_clock; // R7
                        end
                        if (serial_memory_clock_up) begin                              // R6
                            cfg_bit       <= serial_data_in;
                            cfg_bit_valid <= 1'b1;
                            hdr_r         <= {hdr_r[6:0], serial_data_in};
                            if (bits_r != `SRBS_HDR_BITS) begin
                                bits_r <= bits_r + 4'h1;
                            end
                        end
                        if (serial_memory_clock_up && bits_r == `SRBS_HDR_BITS - 4'h1 && hdr_bad) begin // R10
                            state_r             <= SRBS_ST_ERROR;
                            config_error_oe_n   <= 1'b0;
                            memory_enable_n     <= 1'b1;
                            serial_memory_clock <= 1'b0;
                        end else if (cfg_tick && cyc_r == `SRBS_CFG_CYCLES - 14'h1) begin // R14
                            state_r     <= SRBS_ST_TAIL;
                            config_done <= 1'b1;
                            tail_r      <= 2'h0;
                        end
                    end
                    SRBS_ST_TAIL: begin
                        if (cfg_tick) begin                             // R13
                            tail_r              <= tail_r + 2'h1;
                            serial_memory_clock <= 1'b0;
                            if (tail_r == `SRBS_TAIL_CYCLES - 2'h1) begin
                                memory_enable_n <= 1'b1;
                                state_r         <= SRBS_ST_DONE;
                            end
                        end
                    end
                    SRBS_ST_MICRO, SRBS_ST_DONE, SRBS_ST_ERROR: begin
                        // Parked until an event above; byte-wide loading lives outside
                        state_r <= state_r;
                    end
                    default: begin
                        state_r <= SRBS_ST_POR;
                    end
                endcase
            end
        end
    end

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    sequence s_load_entry;
        (state_r != SRBS_ST_LOAD) ##1 (state_r == SRBS_ST_LOAD);
    endsequence
    sequence s_done_rise;
        !config_done ##1 config_done;
    endsequence
    property p_boot_auto;
        (state_r == SRBS_ST_CLEAR && cfg_tick && rows_end && chip_reset_n && boot_select
         && !ap_rise && !pp_rise && !cr_fall && !rb_fall) |=> (state_r == SRBS_ST_LOAD);
    endproperty
    a_boot_auto: assert property (p_boot_auto) else $error("serial boot did not start"); // R1
    property p_int_clk;
        (!clk_source_select && div_r == 3'h3) |=> (cfg_clk_out == 1'b0) ##1 !cfg_clk_oe_n;
    endproperty
    a_int_clk: assert property (p_int_clk) else $error("internal clock output wrong"); // R2
    property p_ext_clk;
        clk_source_select |-> (cfg_tick == cc_rise) ##1 cfg_clk_oe_n;
    endproperty
    a_ext_clk: assert property (p_ext_clk) else $error("external clock not used"); // R3
    property p_hold_idle;
        (state_r == SRBS_ST_HOLD) |-> memory_enable_n && !serial_memory_clock && !config_done;
    endproperty
    a_hold_idle: assert property (p_hold_idle) else $error("activity while held in reset"); // R4
    property p_start;
        s_load_entry |-> !memory_enable_n && !serial_memory_clock;
    endproperty
    a_start: assert property (p_start) else $error("load started without memory enable"); // R5
    property p_capture;
        (state_r == SRBS_ST_LOAD && serial_memory_clock_up && !rb_fall && !ap_rise && !pp_rise && !cr_fall)
        |=> cfg_bit_valid && (serial_memory_clock || state_r == SRBS_ST_ERROR) && (cfg_bit == $past(serial_data_in));
    endproperty
    a_capture: assert property (p_capture) else $error("bit not captured on clock rise"); // R6
    property p_serial_memory_clock;
        (state_r == SRBS_ST_LOAD && !cfg_tick && !rb_fall && !ap_rise && !pp_rise && !cr_fall)
        |=> (serial_memory_clock == $past(serial_memory_clock));
    endproperty
    a_serial_memory_clock: assert property (p_serial_memory_clock) else $error("serial clock moved off tick"); // R7
    property p_reboot;
        (rb_fall && load_ready && !ap_rise && !pp_rise && !cr_fall)
        |=> !config_done && config_error_oe_n && (state_r == SRBS_ST_RBWAIT);
    endproperty
    a_reboot: assert property (p_reboot) else $error("reboot did not clear done and error"); // R8 R11
    property p_release;
        (state_r == SRBS_ST_RBWAIT && reboot_request_n && !ap_rise && !pp_rise && !cr_fall)
        |=> !memory_enable_n;
    endproperty
    a_release: assert property (p_release) else $error("memory enable late after release"); // R12
    property p_error;
        (state_r == SRBS_ST_ERROR) |-> !config_error_oe_n && !config_error_out && memory_enable_n;
    endproperty
    a_error: assert property (p_error) else $error("error state not signalled"); // R10
    property p_done_len;
        s_done_rise |-> (cyc_r == `SRBS_CFG_CYCLES) && !memory_enable_n;
    endproperty
    a_done_len: assert property (p_done_len) else $error("load length wrong"); // R14 R13
    property p_tail;
        (state_r == SRBS_ST_TAIL && cfg_tick && tail_r == 2'h0 && !ap_rise && !pp_rise && !cr_fall
         && !rb_fall) |=> !memory_enable_n;
    endproperty
    a_tail: assert property (p_tail) else $error("memory enable released early"); // R13
    property p_por_clear;
        (state_r == SRBS_ST_POR && cfg_tick && !por_roll && !ap_rise && !pp_rise)
        |=> sram_clear && !analog_enable && (state_r == SRBS_ST_POR);
    endproperty
    a_por_clear: assert property (p_por_clear) else $error("no clearing during power-on stretch"); // R16 R15
endmodule

// file: tb/srbs_eeprom_model.sv
// Serial memory model: header byte first, then an alternating bit pattern.
// Assumes enable and clock come straight from the sequencer pins.
`timescale 1ns/100ps
module srbs_eeprom_model (
    // Memory pins
    input  wire logic       serial_memory_clock,
    input  wire logic       memory_enable_n,
    output logic            serial_data_in,
    // Stored header
    input  wire logic [7:0] hdr
);
    int   idx = 0;
    logic bit_v;
    always @(negedge memory_enable_n) idx = 0;
    // Shift shortly after the rising clock so the captured bit has hold time
    always @(posedge serial_memory_clock) if (!memory_enable_n) idx <= #2 idx + 1;
    assign bit_v = (idx < 8) ? hdr[7 - idx] : idx[0];
    // Released line has no pull, so it shows the inverse
    always @* serial_data_in = memory_enable_n ? ~bit_v : bit_v;
endmodule

// file: tb/test_srbs_top.sv
// Bench for the boot sequencer: power-on hold, full load, reboot, error, hold.
// Assumes the eeprom model and an external 25 MHz configuration clock.
`timescale 1ns/100ps
module test_srbs_top;
    import srbs_pkg::*;
    logic core_clk = 0, rst = 1, hsel = 0, hwrite = 0, boot_select = 1, clk_source_select = 1;
    logic chip_reset_n = 0, reboot_request_n = 1, power_on_pin = 0, analog_power_on_pulse = 0;
    logic [31:0] haddr = 0, q;
    logic [1:0] htrans = 0, cdiv = 0;
    logic [2:0] hsize = 3'h2;
    srbs_word_t hwdata = 0, hrdata;
    logic hreadyout, hresp, cfg_clk_out, cfg_clk_oe_n, smc, men_n, sdi, done, eout, eoe_n;
    logic ana, sclr, cbit, cval, smc_q, done_q, seen_clr = 0;
    logic [6:0] row;
    logic [7:0] hdr = 8'hA5, hdr_got;
    int bad_count = 0, n_compared = 0, n_tog = 0, nbits = 0, i;
    always #5 core_clk = ~core_clk;
    always @(posedge core_clk) cdiv <= cdiv + 2'h1;
    always @(posedge core_clk) begin
        smc_q <= smc;
        done_q <= done;
        if (!men_n && !done_q && smc !== smc_q) n_tog++;
        if (cval === 1'b1 && nbits < 8) begin
            hdr_got <= {hdr_got[6:0], cbit};
            nbits++;
        end
        if (sclr === 1'b1) seen_clr <= 1'b1;
    end
    srbs_top #(.POR_BITS(4)) DUT (.core_clk(core_clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .boot_select(boot_select), .clk_source_select(clk_source_select),
        .chip_reset_n(chip_reset_n), .reboot_request_n(reboot_request_n), .power_on_pin(power_on_pin),
        .analog_power_on_pulse(analog_power_on_pulse), .cfg_clk_in(cdiv[1]), .cfg_clk_out(cfg_clk_out),
        .cfg_clk_oe_n(cfg_clk_oe_n), .serial_memory_clock(smc), .memory_enable_n(men_n),
        .serial_data_in(sdi), .config_done(done), .config_error_out(eout), .config_error_oe_n(eoe_n),
        .analog_enable(ana), .sram_row(row), .sram_clear(sclr), .cfg_bit(cbit), .cfg_bit_valid(cval));
    srbs_eeprom_model mem (.serial_memory_clock(smc), .memory_enable_n(men_n), .serial_data_in(sdi), .hdr(hdr));
    task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task cyc(input int n);
        repeat (n) @(posedge core_clk);
    endtask
    // One single word transfer, holding each phase until hready
    task ahb(input logic wr, input logic [31:0] a, input logic [31:0] d);
        hsel <= 1;
        haddr <= a;
        htrans <= 2'b10;
        hwrite <= wr;
        do @(posedge core_clk); while (hreadyout !== 1'b1);
        hsel <= 0;
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge core_clk); while (hreadyout !== 1'b1);
        q = hrdata;
    endtask
    task end_sim;
        if (bad_count == 0 && n_compared > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    initial begin
        #700000;
        bad_count++;
        end_sim();
    end
    initial begin
        cyc(4);
        rst <= 0;
        cyc(2000);
        chk("hold_men", men_n, 1'b1);
        chk("por_clear", seen_clr, 1'b1);
        chk("clk_pin_in", cfg_clk_oe_n, 1'b1);
        chk("idle_ana", ana, 1'b0);
        chip_reset_n <= 1;
        cyc(3);
        chk("start_men", men_n, 1'b0);
        for (i = 0; i < 60000 && done !== 1'b1; i++) cyc(1);
        cyc(5);
        chk("load_done", done, 1'b1);
        chk("load_ticks", n_tog, 14109);
        chk("header", hdr_got, 8'hA5);
        chk("tail_men", men_n, 1'b0);
        cyc(7);
        chk("rel_men", men_n, 1'b1);
        ahb(0, 32'h0, 32'h0);
        chk("ctrl_rst", q, 32'h1);
        chk("analog", ana, 1'b1);
        reboot_request_n <= 0;
        cyc(12);
        chk("rb_done", done, 1'b0);
        hdr <= 8'h5A;
        cyc(300);
        chk("rb_wait", men_n, 1'b1);
        reboot_request_n <= 1;
        cyc(12);
        chk("rb_men", men_n, 1'b0);
        cyc(200);
        chk("err_pin", eoe_n, 1'b0);
        chk("err_men", men_n, 1'b1);
        ahb(0, 32'h4, 32'h0);
        chk("stat_err", q[5], 1'b1);
        ahb(0, 32'h8, 32'h0);
        chk("expect_rst", q, 32'hA5);
        ahb(1, 32'h8, 32'h5A);
        ahb(0, 32'hC, 32'h0);
        chk("unmapped", q, 32'h0);
        reboot_request_n <= 0;
        cyc(12);
        chk("rb_err", eoe_n, 1'b1);
        reboot_request_n <= 1;
        cyc(300);
        chk("good_hdr", eoe_n, 1'b1);
        chip_reset_n <= 0;
        seen_clr <= 0;
        cyc(600);
        chk("rst_clear", seen_clr, 1'b1);
        chk("rst_idle", men_n, 1'b1);
        clk_source_select <= 0;
        boot_select <= 0;
        chip_reset_n <= 1;
        cyc(3);
        chk("micro_men", men_n, 1'b1);
        chk("clk_pin_out", cfg_clk_oe_n, 1'b0);
        power_on_pin <= 1;
        seen_clr <= 0;
        cyc(2);
        power_on_pin <= 0;
        cyc(40);
        ahb(0, 32'h4, 32'h0);
        chk("por_state", q[3:0], SRBS_ST_POR);
        cyc(800);
        ahb(0, 32'h4, 32'h0);
        chk("micro_state", q[3:0], SRBS_ST_MICRO);
        chk("por_clear2", seen_clr, 1'b1);
        end_sim();
    end
endmodule
